// ==== pkg/mrmc_consts.svh ====
`ifndef MRMC_CONSTS_SVH
`define MRMC_CONSTS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define MRMC_NAC_OFS 8'h00
`define MRMC_STAT_OFS 8'h04

// ------------------------------------------------------------
// Network access control field positions
// ------------------------------------------------------------
`define MRMC_FCOL_BIT 12
`define MRMC_OM_HI 11
`define MRMC_OM_LO 10
`define MRMC_MM_BIT 7
`define MRMC_PROM_BIT 6
`define MRMC_BOFZ_BIT 5
`define MRMC_PB_BIT 3
`define MRMC_RUN_BIT 1

// ------------------------------------------------------------
// Reset values and codes
// ------------------------------------------------------------
`define MRMC_FCOL_RST 1'h0
`define MRMC_OM_RST 2'h0
`define MRMC_MM_RST 1'h0
`define MRMC_PROM_RST 1'h1
`define MRMC_BOFZ_RST 1'h0
`define MRMC_PB_RST 1'h0
`define MRMC_RUN_RST 1'h0
`define MRMC_OM_NORMAL 2'h0
`define MRMC_OM_MACLB 2'h1

// ------------------------------------------------------------
// Status register field positions
// ------------------------------------------------------------
`define MRMC_ST_HI 1
`define MRMC_ST_LO 0
`define MRMC_ST_CARR_BIT 2

`endif

// ==== pkg/mrmc_pkg.sv ====
package mrmc_pkg;

    typedef enum logic [1:0] {
        MRMC_STOP,
        MRMC_RUN,
        MRMC_SUSP,
        MRMC_DRAIN
    } mrmc_rxst_t;

    typedef struct packed {
        logic fcol_en;
        logic [1:0] mode;
        logic mm;
        logic prom;
        logic bo_freeze;
        logic pb;
        logic rx_run;
        mrmc_rxst_t rxst;
        logic wr_pend;
        logic wr_nac;
        logic [31:0] rdata;
        logic readyout;
        logic resp;
        logic cs1;
        logic cs2;
        logic cs3;
        logic carrier_s;
        logic backoff_hold;
        logic force_col;
        logic mac_lb;
        logic accept;
        logic drop;
        logic running;
        logic stopped;
    } mrmc_state_t;

endpackage : mrmc_pkg

// ==== hdl/mrmc_mode_ctrl.sv ====
// Implementation choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ps
`include "mrmc_consts.svh"

module mrmc_mode_ctrl (
    input wire logic clock,
    input wire logic nrst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic carrier,
    input wire logic tx_active,
    input wire logic rx_frame_active,
    input wire logic rx_suspend_req,
    input wire logic rx_resume,
    input wire logic pkt_valid,
    input wire logic pkt_addr_match,
    input wire logic pkt_multicast,
    input wire logic pkt_bad,
    input wire logic pkt_pause,
    input wire logic pkt_wakeup,
    input wire logic pause_enable,
    input wire logic wakeup_enable,
    output logic force_collision,
    output logic mac_loopback,
    output logic backoff_hold,
    output logic pkt_accept,
    output logic pkt_drop,
    output logic rx_running,
    output logic rx_stopped
);

    mrmc_pkg::mrmc_state_t q;
    mrmc_pkg::mrmc_state_t next_q;

    logic addr_phase;
    logic [31:0] nac_word;
    logic [31:0] stat_word;
    logic addr_ok;
    logic quality_ok;
    logic ctl_ok;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    // Only whole-word transfers are used; hsize is not checked
    assign addr_phase = hsel & htrans[1] & hready;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        next_q = q;
        nac_word = 32'h0;
        stat_word = 32'h0;
        addr_ok = 1'b0;
        quality_ok = 1'b0;
        ctl_ok = 1'b0;

        // Data phase of a write; reserved bits dropped
        if (q.wr_pend && q.wr_nac)
        begin
            next_q.fcol_en = hwdata[`MRMC_FCOL_BIT];
            next_q.mode = hwdata[`MRMC_OM_HI:`MRMC_OM_LO];
            next_q.mm = hwdata[`MRMC_MM_BIT];
            next_q.prom = hwdata[`MRMC_PROM_BIT];
            next_q.bo_freeze = hwdata[`MRMC_BOFZ_BIT];
            next_q.pb = hwdata[`MRMC_PB_BIT];
            next_q.rx_run = hwdata[`MRMC_RUN_BIT];
        end

        // Receive processor
        case (q.rxst)
            mrmc_pkg::MRMC_STOP:
            begin
                if (next_q.rx_run)
                    next_q.rxst = mrmc_pkg::MRMC_RUN;
            end
            mrmc_pkg::MRMC_RUN:
            begin
                if (!next_q.rx_run)
                begin
                    // Let the frame on the wire complete
                    if (rx_frame_active)
                        next_q.rxst = mrmc_pkg::MRMC_DRAIN;
                    else
                        next_q.rxst = mrmc_pkg::MRMC_STOP;
                end
                else if (rx_suspend_req)
                    next_q.rxst = mrmc_pkg::MRMC_SUSP;
            end
            mrmc_pkg::MRMC_SUSP:
            begin
                if (!next_q.rx_run)
                    next_q.rxst = mrmc_pkg::MRMC_STOP;
                else if (rx_resume)
                    next_q.rxst = mrmc_pkg::MRMC_RUN;
            end
            mrmc_pkg::MRMC_DRAIN:
            begin
                if (next_q.rx_run)
                    next_q.rxst = mrmc_pkg::MRMC_RUN;
                else if (!rx_frame_active)
                    next_q.rxst = mrmc_pkg::MRMC_STOP;
            end
            default:
            begin
                next_q.rxst = mrmc_pkg::MRMC_STOP;
            end
        endcase

        // Control readback built from the updated copy (status from q), so a read
        // right behind a write sees the new value
        nac_word[`MRMC_FCOL_BIT] = next_q.fcol_en;
        nac_word[`MRMC_OM_HI:`MRMC_OM_LO] = next_q.mode;
        nac_word[`MRMC_MM_BIT] = next_q.mm;
        nac_word[`MRMC_PROM_BIT] = next_q.prom;
        nac_word[`MRMC_BOFZ_BIT] = next_q.bo_freeze;
        nac_word[`MRMC_PB_BIT] = next_q.pb;
        nac_word[`MRMC_RUN_BIT] = next_q.rx_run;
        stat_word[`MRMC_ST_HI:`MRMC_ST_LO] = q.rxst;
        stat_word[`MRMC_ST_CARR_BIT] = q.carrier_s;

        // Address phase
        next_q.wr_pend = addr_phase & hwrite;
        next_q.wr_nac = haddr[7:0] == `MRMC_NAC_OFS;
        if (addr_phase && !hwrite)
        begin
            // Unmapped words and reserved bits read zero
            if (haddr[7:0] == `MRMC_NAC_OFS)
                next_q.rdata = nac_word;
            else if (haddr[7:0] == `MRMC_STAT_OFS)
                next_q.rdata = stat_word;
            else
                next_q.rdata = 32'h0;
        end
        next_q.readyout = 1'b1;
        next_q.resp = 1'b0;

        // Carrier pin: change taken once stages two and three agree
        next_q.cs1 = carrier;
        next_q.cs2 = q.cs1;
        next_q.cs3 = q.cs2;
        if (q.cs2 == q.cs3)
            next_q.carrier_s = q.cs3;

        // MAC controls
        next_q.force_col = q.fcol_en & tx_active;
        next_q.mac_lb = q.mode == `MRMC_OM_MACLB;
        next_q.backoff_hold = q.bo_freeze & q.carrier_s;

        // Receive filter
        addr_ok = q.prom | pkt_addr_match
            | (q.mm & pkt_multicast);
        quality_ok = !pkt_bad | q.pb;
        ctl_ok = !pkt_bad
            & ((pkt_pause & pause_enable)
            | (pkt_wakeup & wakeup_enable));
        next_q.accept = 1'b0;
        next_q.drop = 1'b0;
        if (pkt_valid)
        begin
            case (q.rxst)
                mrmc_pkg::MRMC_RUN,
                mrmc_pkg::MRMC_DRAIN:
                    next_q.accept = addr_ok & quality_ok;
                mrmc_pkg::MRMC_STOP:
                    next_q.accept = ctl_ok;
                default:
                    next_q.accept = 1'b0;
            endcase
            next_q.drop = !next_q.accept;
        end

        next_q.running = next_q.rxst != mrmc_pkg::MRMC_STOP;
        next_q.stopped = next_q.rxst == mrmc_pkg::MRMC_STOP;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            q <= '0;
            q.fcol_en <= `MRMC_FCOL_RST;
            q.mode <= `MRMC_OM_RST;
            q.mm <= `MRMC_MM_RST;
            q.prom <= `MRMC_PROM_RST;
            q.bo_freeze <= `MRMC_BOFZ_RST;
            q.pb <= `MRMC_PB_RST;
            q.rx_run <= `MRMC_RUN_RST;
            q.rxst <= mrmc_pkg::MRMC_STOP;
            q.readyout <= 1'b1;
            q.stopped <= 1'b1;
        end
        else
        begin
            q <= next_q;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign hreadyout = q.readyout;
    assign hresp = q.resp;
    assign hrdata = q.rdata;
    assign force_collision = q.force_col;
    assign mac_loopback = q.mac_lb;
    assign backoff_hold = q.backoff_hold;
    assign pkt_accept = q.accept;
    assign pkt_drop = q.drop;
    assign rx_running = q.running;
    assign rx_stopped = q.stopped;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);

    a_prom_reset: assert property (
        $rose(nrst) |-> q.prom && !q.rx_run)
        else $error("promiscuous bit not set after reset");

    a_force_collide: assert property (
        q.fcol_en && tx_active |=> force_collision)
        else $error("forced collision missing");

    a_mode_loop: assert property (
        q.mode != `MRMC_OM_MACLB |=> !mac_loopback)
        else $error("loopback outside mode 01");

    a_mcast_accept: assert property (
        pkt_valid && q.rxst == mrmc_pkg::MRMC_RUN && q.mm
        && pkt_multicast && !pkt_bad |=> pkt_accept)
        else $error("multicast packet not accepted");

    a_nomatch_drop: assert property (
        pkt_valid && q.rxst == mrmc_pkg::MRMC_RUN && !q.prom
        && !pkt_addr_match && !(q.mm && pkt_multicast)
        |=> pkt_drop && !pkt_accept)
        else $error("unmatched packet accepted");

    a_backoff_freeze: assert property (
        q.carrier_s && q.bo_freeze |=> backoff_hold)
        else $error("back-off not held under carrier");

    a_bad_discard: assert property (
        pkt_valid && pkt_bad && !q.pb
        && q.rxst != mrmc_pkg::MRMC_STOP |=> pkt_drop)
        else $error("bad packet not discarded");

    a_drain_stop: assert property (
        q.rxst == mrmc_pkg::MRMC_DRAIN && !next_q.rx_run
        && !rx_frame_active |=> rx_stopped && !rx_running)
        else $error("receiver did not stop after frame");

    a_stop_ctl: assert property (
        pkt_valid && q.rxst == mrmc_pkg::MRMC_STOP && pkt_pause
        && pause_enable && !pkt_bad |=> pkt_accept)
        else $error("pause packet lost while stopped");

    a_run_start: assert property (
        q.rxst == mrmc_pkg::MRMC_STOP && q.wr_pend && q.wr_nac
        && hwdata[`MRMC_RUN_BIT] |=> rx_running)
        else $error("receiver not started");

    a_rsvd_zero: assert property (
        // Status word shares hrdata, so only control reads count
        addr_phase && !hwrite && haddr[7:0] == `MRMC_NAC_OFS
        |=> hrdata[31:13] == 19'h0 && hrdata[9:8] == 2'h0
        && hrdata[4] == 1'b0 && hrdata[2] == 1'b0
        && hrdata[0] == 1'b0)
        else $error("reserved bits read nonzero");

    c_run_stop: cover property (
        q.rxst == mrmc_pkg::MRMC_RUN
        ##1 q.rxst == mrmc_pkg::MRMC_DRAIN [*2]
        ##1 q.rxst == mrmc_pkg::MRMC_STOP);

    c_prom_accept: cover property (
        q.prom && pkt_valid && !pkt_addr_match ##1 pkt_accept);

    c_suspend: cover property (
        q.rxst == mrmc_pkg::MRMC_SUSP
        ##1 q.rxst == mrmc_pkg::MRMC_RUN);

    a_susp_drop: assert property (
        pkt_valid && q.rxst == mrmc_pkg::MRMC_SUSP
        |=> pkt_drop && !pkt_accept)
        else $error("packet accepted while suspended");

    a_resume_run: assert property (
        q.rxst == mrmc_pkg::MRMC_SUSP && q.rx_run && rx_resume
        && !(q.wr_pend && q.wr_nac) |=> q.rxst == mrmc_pkg::MRMC_RUN)
        else $error("receiver did not resume");

    a_drain_rerun: assert property (
        q.rxst == mrmc_pkg::MRMC_DRAIN && q.wr_pend && q.wr_nac
        && hwdata[`MRMC_RUN_BIT] |=> q.rxst == mrmc_pkg::MRMC_RUN)
        else $error("draining receiver not restarted");

    a_wake_stop: assert property (
        pkt_valid && q.rxst == mrmc_pkg::MRMC_STOP && pkt_wakeup
        && wakeup_enable && !pkt_bad |=> pkt_accept)
        else $error("wake-up packet lost while stopped");

    a_mode_set: assert property (
        q.mode == `MRMC_OM_MACLB |=> mac_loopback)
        else $error("loopback missing in mode 01");

    a_one_answer: assert property (
        pkt_valid |=> pkt_accept != pkt_drop)
        else $error("packet not given exactly one verdict");

    c_drain_rerun: cover property (
        q.rxst == mrmc_pkg::MRMC_DRAIN ##1 q.rxst == mrmc_pkg::MRMC_RUN);

    c_wake_accept: cover property (
        q.rxst == mrmc_pkg::MRMC_STOP && pkt_valid && pkt_wakeup
        ##1 pkt_accept);

endmodule : mrmc_mode_ctrl

// ==== dv/tb_top.sv ====
`timescale 1ns/1ps
`include "mrmc_consts.svh"
`define CHK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_errors++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, ex, got); end end

module tb_top;
    localparam logic [31:0] a_nac = {24'h0, `MRMC_NAC_OFS};
    localparam logic [31:0] a_stat = {24'h0, `MRMC_STAT_OFS};
    logic clock, nrst, hsel, hwrite, carrier, tx_active, rx_frame_active;
    logic rx_suspend_req, rx_resume, pkt_valid, pkt_addr_match;
    logic pkt_multicast, pkt_bad, pkt_pause, pkt_wakeup;
    logic pause_enable, wakeup_enable, hreadyout, hresp;
    logic force_collision, mac_loopback, backoff_hold, pkt_accept;
    logic pkt_drop, rx_running, rx_stopped, mm, prom, pb;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    int n_errors, checks;

    mrmc_mode_ctrl dut (.clock(clock), .nrst(nrst), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .carrier(carrier),
        .tx_active(tx_active), .rx_frame_active(rx_frame_active),
        .rx_suspend_req(rx_suspend_req), .rx_resume(rx_resume),
        .pkt_valid(pkt_valid), .pkt_addr_match(pkt_addr_match),
        .pkt_multicast(pkt_multicast), .pkt_bad(pkt_bad),
        .pkt_pause(pkt_pause), .pkt_wakeup(pkt_wakeup),
        .pause_enable(pause_enable), .wakeup_enable(wakeup_enable),
        .force_collision(force_collision), .mac_loopback(mac_loopback),
        .backoff_hold(backoff_hold), .pkt_accept(pkt_accept),
        .pkt_drop(pkt_drop), .rx_running(rx_running),
        .rx_stopped(rx_stopped));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] nac(input logic f, input logic [1:0] md,
        input logic m, input logic p, input logic s, input logic b,
        input logic r);
        return {19'h0, f, md, 2'h0, m, p, s, 1'h0, b, 1'h0, r, 1'h0};
    endfunction : nac

    // State code: 0 stopped, 1 running, 2 suspended
    function automatic logic exp_acc(input logic [1:0] st, input logic [4:0] at);
        logic m, mc, b, p, w;
        {m, mc, b, p, w} = at;
        if (st == 2'h1)
            return (prom | m | (mm & mc)) & (!b | pb);
        if (st == 2'h0)
            return !b & ((p & pause_enable) | (w & wakeup_enable));
        return 1'h0;
    endfunction : exp_acc

    task automatic xfer(input logic wr, input logic [31:0] a,
        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge clock);
        hsel <= 1'h1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge clock);
        while (hreadyout !== 1'h1) @(posedge clock);
        htrans <= 2'h0;
        hsel <= 1'h0;
        hwdata <= wd;
        @(posedge clock);
        while (hreadyout !== 1'h1) @(posedge clock);
        rd = hrdata;
    endtask : xfer

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        xfer(1'h1, a, d, x);
    endtask : wr

    task automatic rd_chk(input logic [31:0] a, input logic [31:0] ex,
        input string nm);
        logic [31:0] d;
        xfer(1'h0, a, 32'h0, d);
        `CHK(nm, ex, d)
        `CHK("hresp", 1'h0, hresp)
    endtask : rd_chk

    task automatic pkt(input logic [4:0] at, input logic [1:0] st);
        logic ex;
        ex = exp_acc(st, at);
        @(posedge clock);
        {pkt_addr_match, pkt_multicast, pkt_bad, pkt_pause, pkt_wakeup} <= at;
        pkt_valid <= 1'h1;
        @(posedge clock);
        pkt_valid <= 1'h0;
        @(negedge clock);
        `CHK("pkt_accept", ex, pkt_accept)
        `CHK("pkt_drop", !ex, pkt_drop)
    endtask : pkt

    task automatic settle(input int n);
        repeat (n) @(posedge clock);
        @(negedge clock);
    endtask : settle

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------
    // Clock, watchdog, sequence
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    // Whole sequence needs well under 3000 cycles
    initial
    begin
        repeat (20000) @(posedge clock);
        n_errors++;
        report_and_stop();
    end

    initial
    begin
        {nrst, hsel, hwrite, carrier, tx_active, rx_frame_active} = '0;
        {rx_suspend_req, rx_resume, pkt_valid, pkt_addr_match} = '0;
        {pkt_multicast, pkt_bad, pkt_pause, pkt_wakeup} = '0;
        {pause_enable, wakeup_enable, mm, prom, pb} = '0;
        {haddr, hwdata, htrans} = '0;
        hsize = 3'h2;
        n_errors = 0;
        checks = 0;
        void'($urandom(32'h746c));
        repeat (12) @(posedge clock);
        nrst <= 1'h1;
        rd_chk(a_nac, 32'h40, "nac reset");
        `CHK("rx_stopped", 1'h1, rx_stopped)
        wr(a_nac, 32'hffff_fffd);
        rd_chk(a_nac, 32'h0000_1ce8, "nac reserved");
        wr(32'h08, 32'hffff_ffff);
        rd_chk(32'h08, 32'h0, "unmapped");
        $display("test registers done");
        for (int i = 0; i < 8; i++)
        begin
            wr(a_nac, nac(i[2], i[1:0], 1'h0, 1'h1, i[2], 1'h0, 1'h0));
            carrier <= i[0];
            tx_active <= i[1];
            settle(6);
            `CHK("mac_loopback", i[1:0] == 2'h1, mac_loopback)
            `CHK("force_collision", i[2] & i[1], force_collision)
            `CHK("backoff_hold", i[2] & i[0], backoff_hold)
            // Transmit idle again before the next mode write
            @(posedge clock);
            tx_active <= 1'h0;
        end
        carrier <= 1'h0;
        $display("test modes done");
        for (int k = 0; k < 8; k++)
        begin
            mm = $urandom_range(1) != 0;
            prom = $urandom_range(1) != 0;
            pb = $urandom_range(1) != 0;
            pause_enable <= $urandom_range(1) != 0;
            wakeup_enable <= $urandom_range(1) != 0;
            wr(a_nac, nac(1'h0, 2'h0, mm, prom, 1'h0, pb, 1'h0));
            repeat (6) pkt(5'($urandom_range(31)), 2'h0);
            wr(a_nac, nac(1'h0, 2'h0, mm, prom, 1'h0, pb, 1'h1));
            repeat (6) pkt(5'($urandom_range(31)), 2'h1);
            wr(a_nac, nac(1'h0, 2'h0, mm, prom, 1'h0, pb, 1'h0));
        end
        {mm, prom, pb} = 3'h3;
        wr(a_nac, nac(1'h0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1));
        pkt(5'h04, 2'h1);
        $display("test filter done");
        @(posedge clock);
        rx_frame_active <= 1'h1;
        settle(2);
        rd_chk(a_stat, 32'h1, "status run");
        `CHK("rx_running", 1'h1, rx_running)
        wr(a_nac, nac(1'h0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0));
        settle(3);
        `CHK("rx_running", 1'h1, rx_running)
        rd_chk(a_stat, 32'h3, "status drain");
        rx_frame_active <= 1'h0;
        settle(3);
        `CHK("rx_stopped", 1'h1, rx_stopped)
        wr(a_nac, nac(1'h0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h1));
        @(posedge clock);
        rx_suspend_req <= 1'h1;
        @(posedge clock);
        rx_suspend_req <= 1'h0;
        settle(2);
        rd_chk(a_stat, 32'h2, "status suspend");
        pkt(5'h10, 2'h2);
        @(posedge clock);
        rx_resume <= 1'h1;
        @(posedge clock);
        rx_resume <= 1'h0;
        settle(2);
        rd_chk(a_stat, 32'h1, "status resume");
        rx_suspend_req <= 1'h1;
        @(posedge clock);
        rx_suspend_req <= 1'h0;
        settle(2);
        rd_chk(a_stat, 32'h2, "status suspend again");
        wr(a_nac, nac(1'h0, 2'h0, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0));
        settle(3);
        `CHK("rx_stopped", 1'h1, rx_stopped)
        $display("test receive states done");
        report_and_stop();
    end
endmodule : tb_top
